// *** src/service_request_pkg.sv ***
// Constants and types shared by the service request block and its request store.
// Assumes a 100 MHz host-bus clock and eight channel groups of 32 channels.
package service_request_pkg;
  localparam int GROUPS = 8;
  localparam int CHANNELS = 32;
  localparam int ADDR_W = 14;
  // Register offsets inside the function window
  localparam logic [10:0] OFS_GROUP_BASE = 11'h000;
  localparam logic [10:0] OFS_SERVICE_REQ = 11'h004;
  localparam logic [10:0] OFS_GLOBAL_CFG = 11'h600;
  localparam logic [10:0] OFS_UPPER_BASE = 11'h608;
  // Field positions
  localparam int MAP_LSB = 0;
  localparam int MAP_W = 2;
  localparam int BASE_LSB = 11;
  localparam int BASE_W = 21;
  localparam int CODE_LSB = 8;
  localparam int CODE_W = 5;
  localparam int DIR_BIT = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 5;
  localparam int REQ_W = 13;
  // Reset values
  localparam logic [1:0] MAP_RESET = 2'h0;
  localparam logic [31:0] UPPER_RESET = 32'h0000_0000;
  localparam logic [20:0] BASE_RESET = 21'h00_0000;
  // Mapping values
  localparam logic [1:0] MAP_ONE_TO_ONE = 2'h0;
  localparam logic [1:0] MAP_PAIRS = 2'h1;
  localparam logic [1:0] MAP_QUADS = 2'h2;
  localparam logic [1:0] MAP_RESERVED = 2'h3;
  // Request codes
  localparam logic [4:0] REQ_NOOP = 5'h00;
  localparam logic [4:0] REQ_CHIP_RESET = 5'h01;
  localparam logic [4:0] REQ_GROUP_RESET = 5'h02;
  localparam logic [4:0] REQ_GLOBAL_INIT = 5'h04;
  localparam logic [4:0] REQ_GROUP_INIT = 5'h05;
  localparam logic [4:0] REQ_CHAN_ACT = 5'h08;
  localparam logic [4:0] REQ_CHAN_DEACT = 5'h09;
  // Bus commands
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
  // Descriptor fetch slots: 0,1 global init; 2..8 group init
  localparam logic [3:0] FETCH_GLOBAL_FIRST = 4'h0;
  localparam logic [3:0] FETCH_GLOBAL_LAST = 4'h1;
  localparam logic [3:0] FETCH_GROUP_FIRST = 4'h2;
  localparam logic [3:0] FETCH_GROUP_LAST = 4'h8;
  localparam logic [10:0] DESC_GLOBAL_CFG = 11'h600;
  localparam logic [10:0] DESC_INT_QUEUE = 11'h60C;
  localparam logic [10:0] DESC_TIME_SLOT = 11'h200;
  localparam logic [10:0] DESC_SUBCHANNEL = 11'h300;
  localparam logic [10:0] DESC_CHAN_CFG = 11'h380;
  localparam logic [10:0] DESC_GROUP_CFG = 11'h500;
  localparam logic [10:0] DESC_MEM_PROT = 11'h504;
  localparam logic [10:0] DESC_MSG_LEN = 11'h508;
  localparam logic [10:0] DESC_PORT_CFG = 11'h50C;

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_DECODE, ST_ADDR, ST_ADDR_HI, ST_ACK} state_t;
endpackage

// *** src/request_store.sv ***
// Small memory holding the last request word written to each group.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/1ps
module request_store
  import service_request_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic clock, // Bus clock
  input wire logic wrEn, // Write strobe
  input wire logic [$clog2(DEPTH)-1:0] wrAddr, // Write slot
  input wire logic [WIDTH-1:0] wrData, // Write word
  input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Read slot
  output logic [WIDTH-1:0] rdData // Registered read word
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: a slot's read word is only used after its pending flag was set by a write
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// *** src/service_request_host_config.sv ***
// Host-facing configuration and service request interpreter.
// Assumes synchronous register writes and reads from the host bus target.
`timescale 1ns/1ps
// Behaviour
// - Map 0: serial port n feeds channel group n.
// - Map 1: port k feeds groups 2k and 2k+1.
// - Map 2: port 0 feeds groups 0-3, port 1 groups 4-7; 3 reserved.
// - Zero upper base means single addressing, non-zero means dual addressing.
// - Single address: 32-bit address and command in one clock address phase.
// - Dual address: two clock address phase, dual command then real command.
// - Upper 32 address bits come from the upper base register.
// - As target, claim only single-address cycles, never dual-address ones.
// - Group base keeps bits 31:11, bits 10:0 read as zero.
// - Each acknowledged request produces an acknowledge event for its group.
// - One pending request per group, all groups at once, tagged by group.
// - Code 0 does nothing except acknowledge.
// - Code 1 resets map, ports, channels, status pointer and indicators.
// - Code 1 gets no acknowledge and finishes within two line clocks.
// - Code 2 disables group ports and deactivates all its channels.
// - Code 4 fetches global and queue descriptors, resets status pointer.
// - Code 5 fetches seven group descriptors for the group; the direction bit does not change them.
// - Code 8 activates the addressed channel and direction.
// - Code 9 deactivates the addressed channel and direction.
module service_request_host_config
  import service_request_pkg::*;
#(
  parameter int NGROUPS = 8
) (
  input wire logic clock, // Bus clock
  input wire logic rst, // Synchronous reset
  input wire logic regWrite, // Register write strobe
  input wire logic regRead, // Register read strobe
  input wire logic [ADDR_W-1:0] regAddr, // Register byte offset
  input wire logic [31:0] regWdata, // Write data
  output logic [31:0] regRdata, // Read data
  output logic regRvalid, // Read data valid pulse
  input wire logic targetValid, // Target address phase seen
  input wire logic [3:0] targetCmd, // Target command
  output logic targetClaim, // Target claims the cycle
  output logic masterPhase, // Master address phase clock
  output logic masterFirst, // First clock of address phase
  output logic [31:0] masterAd, // Master address lines
  output logic [3:0] masterCbe, // Master command lines
  output logic [3*NGROUPS-1:0] groupPort, // Serial port per group
  output logic [NGROUPS-1:0] portEnable, // Group port enable
  output logic [NGROUPS*CHANNELS-1:0] rxActive, // Receive channel active
  output logic [NGROUPS*CHANNELS-1:0] txActive, // Transmit channel active
  output logic statusReset, // Status pointer and indicator reset pulse
  output logic ackValid, // Acknowledge event pulse
  output logic [2:0] ackGroup, // Acknowledged group
  output logic [4:0] ackCode // Acknowledged code
);
  localparam int NC = NGROUPS * CHANNELS;

  function automatic logic [2:0] mapPort(input logic [1:0] m, input logic [2:0] g);
    case (m)
      MAP_PAIRS: mapPort = {1'b0, g[2:1]};
      MAP_QUADS: mapPort = {2'b00, g[2]};
      default: mapPort = g;
    endcase
  endfunction

  function automatic logic [10:0] descOffset(input logic [3:0] i);
    case (i)
      4'h0: descOffset = DESC_GLOBAL_CFG;
      4'h1: descOffset = DESC_INT_QUEUE;
      4'h2: descOffset = DESC_TIME_SLOT;
      4'h3: descOffset = DESC_SUBCHANNEL;
      4'h4: descOffset = DESC_CHAN_CFG;
      4'h5: descOffset = DESC_GROUP_CFG;
      4'h6: descOffset = DESC_MEM_PROT;
      4'h7: descOffset = DESC_MSG_LEN;
      default: descOffset = DESC_PORT_CFG;
    endcase
  endfunction

  logic [1:0] port_group_map_r, port_group_map_nxt;
  logic [31:0] upper_r, upper_nxt;
  logic [NGROUPS-1:0][BASE_W-1:0] base_r, base_nxt;
  logic [NGROUPS-1:0] pending_r, pending_nxt;
  state_t state_r, state_nxt;
  logic [2:0] group_r, group_nxt;
  logic [REQ_W-1:0] req_r, req_nxt;
  logic [3:0] fetch_r, fetch_nxt, last_r, last_nxt;
  logic [31:0] regRdata_nxt, masterAd_nxt;
  logic [3:0] masterCbe_nxt;
  logic regRvalid_nxt, targetClaim_nxt, masterPhase_nxt, masterFirst_nxt;
  logic [3*NGROUPS-1:0] groupPort_nxt;
  logic [NGROUPS-1:0] portEnable_nxt;
  logic [NC-1:0] rxActive_nxt, txActive_nxt;
  logic statusReset_nxt, ackValid_nxt;
  logic [2:0] ackGroup_nxt, pick;
  logic [4:0] ackCode_nxt;
  logic [REQ_W-1:0] storeRd;
  logic storeWr;
  logic [2:0] regGroup;
  logic [10:0] regSub;
  logic anyPending;

  assign regGroup = regAddr[13:11];
  assign regSub = regAddr[10:0];
  assign storeWr = regWrite && regSub == OFS_SERVICE_REQ;

  request_store #(.DEPTH(NGROUPS), .WIDTH(REQ_W)) reqStore (
    .clock(clock),
    .wrEn(storeWr),
    .wrAddr(regGroup),
    .wrData(regWdata[REQ_W-1:0]),
    .rdAddr(pick),
    .rdData(storeRd)
  );

  always_comb begin
    pick = 3'h0;
    anyPending = 1'b0;
    for (int g = NGROUPS - 1; g >= 0; g--) begin
      if (pending_r[g]) begin
        pick = 3'(g);
        anyPending = 1'b1;
      end
    end
  end

  always_comb begin
    logic [4:0] code;
    logic [7:0] idx;
    logic [31:0] low;
    code = req_r[CODE_LSB +: CODE_W];
    idx = {group_r, req_r[CH_LSB +: CH_W]};
    low = {base_r[group_r], 11'h000} + {21'h00_0000, descOffset(fetch_r)};
    port_group_map_nxt = port_group_map_r;
    upper_nxt = upper_r;
    base_nxt = base_r;
    pending_nxt = pending_r;
    state_nxt = state_r;
    group_nxt = group_r;
    req_nxt = req_r;
    fetch_nxt = fetch_r;
    last_nxt = last_r;
    regRdata_nxt = 32'h0000_0000;
    regRvalid_nxt = regRead;
    targetClaim_nxt = targetValid && targetCmd != CMD_DUAL_ADDR;
    masterPhase_nxt = 1'b0;
    masterFirst_nxt = 1'b0;
    masterAd_nxt = 32'h0000_0000;
    masterCbe_nxt = 4'h0;
    portEnable_nxt = portEnable;
    rxActive_nxt = rxActive;
    txActive_nxt = txActive;
    statusReset_nxt = 1'b0;
    ackValid_nxt = 1'b0;
    ackGroup_nxt = ackGroup;
    ackCode_nxt = ackCode;
    for (int g = 0; g < NGROUPS; g++) begin
      groupPort_nxt[3*g +: 3] = mapPort(port_group_map_r, 3'(g));
    end
    if (regRead) begin
      if (regSub == OFS_GROUP_BASE) begin
        regRdata_nxt = {base_r[regGroup], 11'h000};
      end else if (regGroup == 3'h0 && regSub == OFS_GLOBAL_CFG) begin
        regRdata_nxt = {30'h0000_0000, port_group_map_r};
      end else if (regGroup == 3'h0 && regSub == OFS_UPPER_BASE) begin
        regRdata_nxt = upper_r;
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (anyPending) begin
          group_nxt = pick;
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        req_nxt = storeRd;
        state_nxt = ST_DECODE;
      end
      ST_DECODE: begin
        pending_nxt[group_r] = 1'b0;
        state_nxt = ST_ACK;
        case (code)
          REQ_CHIP_RESET: begin
            // Done in one clock, far inside the two line clock budget; no acknowledge
            port_group_map_nxt = MAP_RESET;
            portEnable_nxt = '0;
            rxActive_nxt = '0;
            txActive_nxt = '0;
            pending_nxt = '0;
            statusReset_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
          REQ_GROUP_RESET: begin
            portEnable_nxt[group_r] = 1'b0;
            rxActive_nxt[32*group_r +: 32] = '0;
            txActive_nxt[32*group_r +: 32] = '0;
          end
          REQ_GLOBAL_INIT: begin
            fetch_nxt = FETCH_GLOBAL_FIRST;
            last_nxt = FETCH_GLOBAL_LAST;
            statusReset_nxt = 1'b1;
            state_nxt = ST_ADDR;
          end
          REQ_GROUP_INIT: begin
            fetch_nxt = FETCH_GROUP_FIRST;
            last_nxt = FETCH_GROUP_LAST;
            state_nxt = ST_ADDR;
          end
          REQ_CHAN_ACT: begin
            if (req_r[DIR_BIT]) txActive_nxt[idx] = 1'b1;
            else rxActive_nxt[idx] = 1'b1;
          end
          REQ_CHAN_DEACT: begin
            if (req_r[DIR_BIT]) txActive_nxt[idx] = 1'b0;
            else rxActive_nxt[idx] = 1'b0;
          end
          default: ;
        endcase
      end
      ST_ADDR: begin
        masterPhase_nxt = 1'b1;
        masterFirst_nxt = 1'b1;
        masterAd_nxt = low;
        if (upper_r != 32'h0000_0000) begin
          masterCbe_nxt = CMD_DUAL_ADDR;
          state_nxt = ST_ADDR_HI;
        end else begin
          masterCbe_nxt = CMD_MEM_READ;
          fetch_nxt = fetch_r + 4'h1;
          state_nxt = fetch_r == last_r ? ST_ACK : ST_ADDR;
        end
      end
      ST_ADDR_HI: begin
        masterPhase_nxt = 1'b1;
        masterAd_nxt = upper_r;
        masterCbe_nxt = CMD_MEM_READ;
        fetch_nxt = fetch_r + 4'h1;
        state_nxt = fetch_r == last_r ? ST_ACK : ST_ADDR;
      end
      default: begin
        if (code == REQ_GROUP_INIT) portEnable_nxt[group_r] = 1'b1;
        ackValid_nxt = 1'b1;
        ackGroup_nxt = group_r;
        ackCode_nxt = code;
        state_nxt = ST_IDLE;
      end
    endcase
    if (regWrite) begin
      if (regSub == OFS_GROUP_BASE) begin
        base_nxt[regGroup] = regWdata[BASE_LSB +: BASE_W];
      end else if (regSub == OFS_SERVICE_REQ) begin
        pending_nxt[regGroup] = 1'b1;
      end else if (regGroup == 3'h0 && regSub == OFS_GLOBAL_CFG) begin
        if (regWdata[MAP_LSB +: MAP_W] != MAP_RESERVED) begin
          port_group_map_nxt = regWdata[MAP_LSB +: MAP_W];
        end
      end else if (regGroup == 3'h0 && regSub == OFS_UPPER_BASE) begin
        upper_nxt = regWdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port_group_map_r <= MAP_RESET;
      upper_r <= UPPER_RESET;
      base_r <= {NGROUPS{BASE_RESET}};
      pending_r <= '0;
      state_r <= ST_IDLE;
      group_r <= 3'h0;
      req_r <= '0;
      fetch_r <= 4'h0;
      last_r <= 4'h0;
      regRdata <= 32'h0000_0000;
      regRvalid <= 1'b0;
      targetClaim <= 1'b0;
      masterPhase <= 1'b0;
      masterFirst <= 1'b0;
      masterAd <= 32'h0000_0000;
      masterCbe <= 4'h0;
      groupPort <= '0;
      portEnable <= '0;
      rxActive <= '0;
      txActive <= '0;
      statusReset <= 1'b0;
      ackValid <= 1'b0;
      ackGroup <= 3'h0;
      ackCode <= 5'h00;
    end else begin
      port_group_map_r <= port_group_map_nxt;
      upper_r <= upper_nxt;
      base_r <= base_nxt;
      pending_r <= pending_nxt;
      state_r <= state_nxt;
      group_r <= group_nxt;
      req_r <= req_nxt;
      fetch_r <= fetch_nxt;
      last_r <= last_nxt;
      regRdata <= regRdata_nxt;
      regRvalid <= regRvalid_nxt;
      targetClaim <= targetClaim_nxt;
      masterPhase <= masterPhase_nxt;
      masterFirst <= masterFirst_nxt;
      masterAd <= masterAd_nxt;
      masterCbe <= masterCbe_nxt;
      groupPort <= groupPort_nxt;
      portEnable <= portEnable_nxt;
      rxActive <= rxActive_nxt;
      txActive <= txActive_nxt;
      statusReset <= statusReset_nxt;
      ackValid <= ackValid_nxt;
      ackGroup <= ackGroup_nxt;
      ackCode <= ackCode_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_map_identity: assert property (port_group_map_r == MAP_ONE_TO_ONE |=>
      groupPort == 24'hFAC688) else $error("one to one map wrong");
  chk_map_pairs: assert property (port_group_map_r == MAP_PAIRS |=>
      groupPort == 24'h6D2240) else $error("pair map wrong");
  chk_map_quads: assert property (port_group_map_r == MAP_QUADS |=>
      groupPort == 24'h249000) else $error("quad map wrong");
  chk_map_reserved: assert property (regWrite && regGroup == 3'h0
      && regSub == OFS_GLOBAL_CFG && regWdata[1:0] == MAP_RESERVED && state_r != ST_DECODE
      |=> $stable(port_group_map_r)) else $error("reserved map changed mapping");

  sequence singlePhase;
    masterFirst && masterCbe == CMD_MEM_READ ##1 !masterPhase || masterFirst;
  endsequence
  sequence dualPhase;
    masterFirst && masterCbe == CMD_DUAL_ADDR
      ##1 masterPhase && !masterFirst && masterCbe == CMD_MEM_READ && masterAd == upper_r;
  endsequence
  chk_single_addr: assert property (state_r == ST_ADDR && upper_r == 32'h0
      |=> singlePhase) else $error("single address phase wrong");
  chk_dual_addr: assert property (state_r == ST_ADDR && upper_r != 32'h0
      && $stable(upper_r) |=> dualPhase) else $error("dual address phase wrong");
  chk_target_dac: assert property (targetValid && targetCmd == CMD_DUAL_ADDR
      |=> !targetClaim) else $error("dual address cycle claimed");
  chk_base_align: assert property (regRvalid && $past(regSub) == OFS_GROUP_BASE
      |-> regRdata[10:0] == 11'h000) else $error("base pointer not aligned");
  chk_noop_ack: assert property (state_r == ST_DECODE && req_r[12:8] == REQ_NOOP
      |=> ##1 ackValid && ackGroup == $past(group_r, 2)) else $error("no-op not acknowledged");
  chk_reset_noack: assert property (state_r == ST_DECODE
      && req_r[12:8] == REQ_CHIP_RESET |=> statusReset && !ackValid ##1 !ackValid
      && port_group_map_r == MAP_RESET || $past(regWrite)) else $error("chip reset misbehaved");
endmodule

// *** testbench/host_bus_model.sv ***
// Host side: memory target logging master address phases, and a per-group record of the acks seen.
// Assumes the device's registered master and acknowledge outputs on the bus clock.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clock, // Bus clock
  input wire logic masterPhase, // Address phase clock
  input wire logic masterFirst, // First phase clock
  input wire logic [31:0] masterAd, // Address lines
  input wire logic [3:0] masterCbe, // Command lines
  input wire logic ackValid, // Acknowledge event
  input wire logic [2:0] ackGroup // Acknowledged group
);
  logic [36:0] phaseLog[$];
  logic [7:0] ackSeen;
  initial ackSeen = 8'h00;
  // Every phase clock is kept whole so dual cycles can be checked for pairing
  always @(posedge clock) begin
    if (masterPhase) begin
      phaseLog.push_back({masterFirst, masterCbe, masterAd});
    end
    if (ackValid) begin
      ackSeen[ackGroup] = 1'b1;
    end
  end
endmodule

// *** testbench/service_request_host_config_tb.sv ***
// Self-checking bench for the service request block.
// Assumes the host model beside it; inputs change on the falling edge.
`timescale 1ns/1ps
module service_request_host_config_tb;
  import service_request_pkg::*;
  logic clock, rst, regWrite, regRead, regRvalid, targetValid, targetClaim;
  logic masterPhase, masterFirst, statusReset, ackValid, sawReset;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0] regWdata, regRdata, masterAd, upper;
  logic [3:0] targetCmd, masterCbe;
  logic [23:0] groupPort;
  logic [7:0] portEnable;
  logic [255:0] rxActive, txActive;
  logic [2:0] ackGroup;
  logic [4:0] ackCode, ch;
  logic [31:0] bases[8];
  logic [10:0] glbOfs[2] = '{DESC_GLOBAL_CFG, DESC_INT_QUEUE};
  logic [10:0] grpOfs[7] = '{DESC_TIME_SLOT, DESC_SUBCHANNEL, DESC_CHAN_CFG, DESC_GROUP_CFG,
    DESC_MEM_PROT, DESC_MSG_LEN, DESC_PORT_CFG};
  int miscompares, tests_run, n;
  int mapSeq[4] = '{1, 2, 3, 0};

  service_request_host_config #(.NGROUPS(8)) DUT (.clock(clock), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .targetValid(targetValid),
    .targetCmd(targetCmd), .targetClaim(targetClaim), .masterPhase(masterPhase),
    .masterFirst(masterFirst), .masterAd(masterAd), .masterCbe(masterCbe),
    .groupPort(groupPort), .portEnable(portEnable), .rxActive(rxActive),
    .txActive(txActive), .statusReset(statusReset), .ackValid(ackValid),
    .ackGroup(ackGroup), .ackCode(ackCode));
  host_bus_model host (.clock(clock), .masterPhase(masterPhase), .masterFirst(masterFirst),
    .masterAd(masterAd), .masterCbe(masterCbe), .ackValid(ackValid), .ackGroup(ackGroup));

  always #5 clock = ~clock;
  always @(posedge clock) if (statusReset) sawReset = 1'b1;

  function automatic logic [23:0] mapExp(input int m);
    logic [23:0] r;
    for (int g = 0; g < 8; g++) begin
      r[3*g +: 3] = (m == 0) ? 3'(g) : (m == 1) ? 3'(g / 2) : 3'(g / 4);
    end
    return r;
  endfunction

  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    check("regRvalid", regRvalid, 1'b1);
    check("regRdata", regRdata, exp);
  endtask

  // Junk in the reserved upper bits must not change the decode
  task automatic req(input logic [2:0] g, input logic [4:0] code, input logic dir);
    wr({g, OFS_SERVICE_REQ}, {19'($urandom), code, 2'h0, dir, ch});
  endtask

  task automatic waitAck(input logic [2:0] g, input logic [4:0] code);
    n = 0;
    while (ackValid !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    // The pulse itself decides, so an ack on the last polled edge is not a timeout
    if (ackValid !== 1'b1) begin
      miscompares++;
      $display("unexpected ack wait: expected 1 seen 0");
      tally_and_finish();
    end else begin
      check("ackGroup", ackGroup, g);
      check("ackCode", ackCode, code);
    end
  endtask

  task automatic fetch(input logic [31:0] base, input bit grp);
    int cnt;
    logic [31:0] a;
    cnt = grp ? 7 : 2;
    check("phases", host.phaseLog.size(), cnt * ((upper == 0) ? 1 : 2));
    for (int i = 0; i < cnt; i++) begin
      a = base + (grp ? grpOfs[i] : glbOfs[i]);
      if (upper == 32'h0) begin
        check("single", host.phaseLog[i], {1'b1, CMD_MEM_READ, a});
      end else begin
        check("dualLow", host.phaseLog[2*i], {1'b1, CMD_DUAL_ADDR, a});
        check("dualHigh", host.phaseLog[2*i+1], {1'b0, CMD_MEM_READ, upper});
      end
    end
    host.phaseLog.delete();
  endtask

  // Host duty after every reset: initialize each group in both directions
  task automatic initAll;
    for (int g = 0; g < 8; g++) begin
      for (int d = 0; d < 2; d++) begin
        req(3'(g), REQ_GROUP_INIT, 1'(d));
        waitAck(3'(g), REQ_GROUP_INIT);
        fetch(bases[g], 1'b1);
      end
    end
    check("portEnable", portEnable, 8'hFF);
  endtask

  initial begin
    clock = 0;
    rst = 1;
    regWrite = 0;
    regRead = 0;
    regAddr = '0;
    regWdata = '0;
    targetValid = 0;
    targetCmd = '0;
    upper = '0;
    ch = '0;
    sawReset = 0;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(50));
    repeat (5) @(negedge clock);
    check("ackValid", ackValid, 1'b0);
    rst = 0;
    repeat (2) @(negedge clock);
    check("groupPort", groupPort, mapExp(0));
    $display("test reset done");
    foreach (mapSeq[i]) begin
      wr(14'h0600, 32'(mapSeq[i]));
      repeat (2) @(negedge clock);
      check("groupPort", groupPort, mapExp(mapSeq[i] == 3 ? 2 : mapSeq[i]));
    end
    $display("test port map done");
    for (int g = 0; g < 8; g++) begin
      bases[g] = $urandom & 32'hFFFF_F800;
      wr({3'(g), OFS_GROUP_BASE}, bases[g] | 32'($urandom & 32'h7FF));
      rd({3'(g), OFS_GROUP_BASE}, bases[g]);
    end
    rd(14'h0010, 32'h0);
    rd({3'h2, OFS_SERVICE_REQ}, 32'h0);
    upper = $urandom | 32'h1;
    wr(14'h0608, upper);
    rd(14'h0608, upper);
    $display("test registers done");
    initAll();
    $display("test group init done");
    repeat (16) begin
      @(negedge clock);
      targetValid = 1'b1;
      targetCmd = ($urandom % 3 == 0) ? CMD_DUAL_ADDR : 4'($urandom);
      @(negedge clock);
      targetValid = 1'b0;
      check("targetClaim", targetClaim, targetCmd != CMD_DUAL_ADDR);
    end
    $display("test target done");
    req(4, REQ_GROUP_INIT, 1'b1);
    waitAck(4, REQ_GROUP_INIT);
    fetch(bases[4], 1'b1);
    sawReset = 0;
    req(4, REQ_GLOBAL_INIT, 1'b0);
    waitAck(4, REQ_GLOBAL_INIT);
    fetch(bases[4], 1'b0);
    check("statusReset", sawReset, 1'b1);
    upper = 32'h0;
    wr(14'h0608, upper);
    req(6, REQ_GROUP_INIT, 1'b0);
    waitAck(6, REQ_GROUP_INIT);
    fetch(bases[6], 1'b1);
    check("portEnable", portEnable, 8'hFF);
    $display("test fetches done");
    host.ackSeen = 8'h00;
    for (int g = 0; g < 8; g++) begin
      req(3'(g), REQ_NOOP, 1'b0);
    end
    for (n = 0; n < 300 && host.ackSeen !== 8'hFF; n++) @(negedge clock);
    check("ackSeen", host.ackSeen, 8'hFF);
    check("noopPhases", host.phaseLog.size(), 0);
    $display("test all groups done");
    ch = 5'($urandom);
    req(3, REQ_CHAN_ACT, 1'b0);
    waitAck(3, REQ_CHAN_ACT);
    req(3, REQ_CHAN_ACT, 1'b1);
    waitAck(3, REQ_CHAN_ACT);
    @(negedge clock);
    check("rxOn", rxActive[96+ch], 1'b1);
    check("txOn", txActive[96+ch], 1'b1);
    req(3, REQ_CHAN_DEACT, 1'b1);
    waitAck(3, REQ_CHAN_DEACT);
    @(negedge clock);
    check("txOff", txActive[96+ch], 1'b0);
    req(3, REQ_GROUP_INIT, 1'b0);
    waitAck(3, REQ_GROUP_INIT);
    fetch(bases[3], 1'b1);
    req(3, REQ_GROUP_RESET, 1'b0);
    waitAck(3, REQ_GROUP_RESET);
    @(negedge clock);
    check("portEnable", portEnable, 8'hF7);
    check("rxGroup", rxActive[127:96], 32'h0);
    $display("test group reset done");
    wr(14'h0600, 32'h1);
    // A live channel elsewhere gives the chip reset something to clear
    req(1, REQ_CHAN_ACT, 1'b1);
    waitAck(1, REQ_CHAN_ACT);
    sawReset = 0;
    n = 0;
    req(5, REQ_CHIP_RESET, 1'b0);
    repeat (20) begin
      @(negedge clock);
      if (ackValid) n++;
    end
    check("chipAcks", n, 0);
    check("statusReset", sawReset, 1'b1);
    check("groupPort", groupPort, mapExp(0));
    check("portEnable", portEnable, 8'h00);
    check("rxActive", rxActive, 256'h0);
    check("txActive", txActive, 256'h0);
    $display("test chip reset done");
    initAll();
    $display("test init after reset done");
    tally_and_finish();
  end
endmodule
